// >>> rtl/tdms_addr_map.sv
`timescale 1ns/1ps
// How it works
// RULE1: address bit 13 high sends host access to data or connection memory.
// RULE2: address bit 13 low means register access only, never memory.
// RULE3: control bits 1:0 pick data memory, connection memory low or high.
// RULE4: in memory space bits 12:8 give stream, bits 7:0 give channel.
// RULE5: channels 0-31 valid at lowest rate, 0-63 at next rate.
// RULE6: channels 0-127 valid at third rate, 0-255 at highest rate.
// RULE7: one read-only 16-bit error count per stream at 0360h-037Fh.
// RULE8: error counters hold at maximum instead of wrapping.
module tdms_addr_map (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [tdms_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [tdms_pkg::DATA_W-1:0] host_wdata,
  input  wire logic                      host_wr,
  input  wire logic                      host_rd,
  output logic      [tdms_pkg::DATA_W-1:0] host_rdata,
  output logic                           host_rvalid,
  input  wire logic [2*tdms_pkg::NUM_STREAMS-1:0] stream_rate,
  input  wire logic [tdms_pkg::NUM_STREAMS-1:0]   ber_error,
  input  wire logic [tdms_pkg::NUM_STREAMS-1:0]   ber_clear,
  output logic                           mem_req,
  output logic                           mem_we,
  output logic      [1:0]                mem_sel,
  output logic      [tdms_pkg::STREAM_W-1:0] mem_stream,
  output logic      [tdms_pkg::CHAN_W-1:0]   mem_chan,
  output logic      [tdms_pkg::DATA_W-1:0]   mem_wdata,
  input  wire logic [tdms_pkg::DATA_W-1:0]   mem_rdata
);
  import tdms_pkg::*;

  tdms_ber_if ber ();

  logic [1:0]          ctrl_sel_q;
  tdms_kind_t          kind1_q;
  logic                rd1_q;
  logic [STREAM_W-1:0] ber_idx_q;
  logic                acc;
  logic                in_mem;
  logic [STREAM_W-1:0] strm;
  logic [CHAN_W-1:0]   chan;
  tdms_rate_t          rate_cur;
  logic                mem_ok;
  logic                is_ber;
  logic [13:0]         ber_off;
  tdms_kind_t          kind;

  // field split of the host address
  assign acc      = host_rd || host_wr;
  assign in_mem   = host_addr[MEM_SPACE_BIT]; // [RULE1] [RULE2]
  assign strm     = host_addr[STREAM_MSB:STREAM_LSB]; // [RULE4]
  assign chan     = host_addr[CHAN_MSB:CHAN_LSB]; // [RULE4]
  assign rate_cur = tdms_rate_t'(stream_rate[2*strm +: 2]);
  // channels past the frame of the stream's rate are dropped [RULE5] [RULE6]
  assign mem_ok   = tdms_chan_ok(rate_cur, chan) &&
                    (tdms_mem_sel_t'(ctrl_sel_q) != TDMS_SEL_RSVD);
  assign ber_off  = host_addr - BER_ERR_BASE;
  assign is_ber   = !in_mem && host_addr >= BER_ERR_BASE && host_addr <= BER_ERR_LAST;

  // classify the access; register space never reaches memory
  always_comb begin
    kind = TDMS_KIND_NONE;
    if (in_mem) begin
      if (mem_ok) kind = TDMS_KIND_MEM; // [RULE1]
    end else if (host_addr == CTRL_REG_ADDR) begin
      kind = TDMS_KIND_CTRL; // [RULE2]
    end else if (is_ber) begin
      kind = TDMS_KIND_BER; // [RULE7]
    end
  end

  // control register: only the memory select field is stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_sel_q <= CTRL_RESET;
    end else if (host_wr && kind == TDMS_KIND_CTRL) begin
      ctrl_sel_q <= host_wdata[CTRL_SEL_MSB:CTRL_SEL_LSB]; // [RULE3]
    end
  end

  // memory request, registered one cycle after the host strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_sel    <= 2'h0;
      mem_stream <= 5'h00;
      mem_chan   <= 8'h00;
      mem_wdata  <= 16'h0000;
    end else begin
      mem_req <= acc && kind == TDMS_KIND_MEM; // [RULE1]
      mem_we  <= host_wr && kind == TDMS_KIND_MEM;
      if (acc && kind == TDMS_KIND_MEM) begin
        mem_sel    <= ctrl_sel_q; // [RULE3]
        mem_stream <= strm; // [RULE4]
        mem_chan   <= chan; // [RULE4]
        mem_wdata  <= host_wdata;
      end
    end
  end

  // read pipeline: decode stage, then data stage, so every read takes two cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd1_q     <= 1'b0;
      kind1_q   <= TDMS_KIND_NONE;
      ber_idx_q <= 5'h00;
    end else begin
      rd1_q   <= host_rd;
      kind1_q <= host_rd ? kind : TDMS_KIND_NONE;
      if (host_rd && kind == TDMS_KIND_BER) ber_idx_q <= ber_off[STREAM_W-1:0]; // [RULE7]
    end
  end

  // answer; unmapped registers and refused memory reads return zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rvalid <= 1'b0;
      host_rdata  <= 16'h0000;
    end else begin
      host_rvalid <= rd1_q;
      unique case (kind1_q)
        TDMS_KIND_CTRL: host_rdata <= {14'h0000, ctrl_sel_q};
        TDMS_KIND_BER:  host_rdata <= ber.count; // [RULE7]
        TDMS_KIND_MEM:  host_rdata <= mem_rdata;
        TDMS_KIND_NONE: host_rdata <= 16'h0000;
      endcase
    end
  end

  assign ber.err   = ber_error;
  assign ber.clr   = ber_clear;
  assign ber.index = ber_idx_q;

  tdms_ber_bank #(
    .STREAMS (NUM_STREAMS)
  ) u_bank (
    .clk     (clk),
    .reset_n (reset_n),
    .ber     (ber.bank)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ber_read;
    host_rd && is_ber;
  endsequence

  sequence s_answer;
    ##2 host_rvalid;
  endsequence

  property p_mem_route;
    acc && in_mem && mem_ok |=> mem_req;
  endproperty
  a_mem_route: assert property (p_mem_route) else $error("memory access not routed"); // [RULE1]

  property p_reg_only;
    acc && !in_mem |=> !mem_req;
  endproperty
  a_reg_only: assert property (p_reg_only) else $error("register access reached memory"); // [RULE2]

  property p_sel_follow;
    mem_req |-> mem_sel == $past(ctrl_sel_q) && mem_sel != 2'h3;
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("memory select wrong"); // [RULE3]

  property p_fields;
    mem_req |-> mem_stream == $past(host_addr[12:8]) && mem_chan == $past(host_addr[7:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("stream or channel field wrong"); // [RULE4]

  property p_low_rates;
    acc && in_mem && ((rate_cur == TDMS_RATE_2M && chan > 8'h1F) ||
                      (rate_cur == TDMS_RATE_4M && chan > 8'h3F)) |=> !mem_req;
  endproperty
  a_low_rates: assert property (p_low_rates) else $error("out-of-frame channel taken"); // [RULE5]

  property p_high_rates;
    acc && in_mem && ctrl_sel_q != 2'h3 &&
      ((rate_cur == TDMS_RATE_8M && chan <= 8'h7F) || rate_cur == TDMS_RATE_16M) |=> mem_req;
  endproperty
  a_high_rates: assert property (p_high_rates) else $error("valid channel refused"); // [RULE6]

  property p_ber_answer;
    s_ber_read |-> s_answer;
  endproperty
  a_ber_answer: assert property (p_ber_answer) else $error("ber read not answered"); // [RULE7]

  property p_ber_data;
    s_ber_read ##1 !ber_clear[ber_idx_q] && !ber_error[ber_idx_q] |=>
      host_rdata == $past(ber.count);
  endproperty
  a_ber_data: assert property (p_ber_data) else $error("ber read data wrong"); // [RULE7]

  sequence s_mem_read;
    host_rd && in_mem && mem_ok;
  endsequence

  // memory data comes back on the answer cycle, neither early nor late
  property p_mem_read_data;
    s_mem_read |-> ##2 (host_rvalid && host_rdata == $past(mem_rdata));
  endproperty
  a_mem_read_data: assert property (p_mem_read_data) else $error("mem read wrong"); // [RULE1]

  property p_mem_write;
    host_wr && in_mem && mem_ok |=> mem_we && mem_wdata == $past(host_wdata);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("mem write lost"); // [RULE1]

  property p_mem_not_reg;
    host_wr && in_mem |=> ctrl_sel_q == $past(ctrl_sel_q);
  endproperty
  a_mem_not_reg: assert property (p_mem_not_reg) else $error("reg hit by mem"); // [RULE2]

  property p_ctrl_store;
    host_wr && !in_mem && host_addr == CTRL_REG_ADDR |=> ctrl_sel_q == $past(host_wdata[1:0]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("select not stored"); // [RULE3]

  property p_ber_no_mem;
    acc && is_ber |=> !mem_req;
  endproperty
  a_ber_no_mem: assert property (p_ber_no_mem) else $error("ber reached mem"); // [RULE7]

endmodule : tdms_addr_map

// >>> rtl/tdms_pkg.sv
package tdms_pkg;

  localparam int ADDR_W      = 14;
  localparam int DATA_W      = 16;
  localparam int NUM_STREAMS = 32;
  localparam int STREAM_W    = 5;
  localparam int CHAN_W      = 8;

  // address fields of the host port
  localparam int MEM_SPACE_BIT = 13;
  localparam int STREAM_MSB    = 12;
  localparam int STREAM_LSB    = 8;
  localparam int CHAN_MSB      = 7;
  localparam int CHAN_LSB      = 0;

  // register space, word offsets
  localparam logic [13:0] CTRL_REG_ADDR = 14'h0000;
  localparam logic [13:0] BER_ERR_BASE  = 14'h0360;
  localparam logic [13:0] BER_ERR_LAST  = 14'h037F;

  // control register layout and reset
  localparam int          CTRL_SEL_LSB = 0;
  localparam int          CTRL_SEL_MSB = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;

  localparam logic [15:0] BER_COUNT_MAX = 16'hFFFF;

  // highest channel number per stream rate
  localparam logic [7:0] CHAN_MAX_2M  = 8'h1F;
  localparam logic [7:0] CHAN_MAX_4M  = 8'h3F;
  localparam logic [7:0] CHAN_MAX_8M  = 8'h7F;
  localparam logic [7:0] CHAN_MAX_16M = 8'hFF;

  typedef enum logic [1:0] {
    TDMS_SEL_DATA,
    TDMS_SEL_CM_LOW,
    TDMS_SEL_CM_HIGH,
    TDMS_SEL_RSVD
  } tdms_mem_sel_t;

  typedef enum logic [1:0] {
    TDMS_RATE_2M,
    TDMS_RATE_4M,
    TDMS_RATE_8M,
    TDMS_RATE_16M
  } tdms_rate_t;

  typedef enum logic [1:0] {
    TDMS_KIND_NONE,
    TDMS_KIND_CTRL,
    TDMS_KIND_BER,
    TDMS_KIND_MEM
  } tdms_kind_t;

  // channel lies inside the frame of a stream at this rate
  function automatic logic tdms_chan_ok(input tdms_rate_t rate, input logic [7:0] chan);
    unique case (rate)
      TDMS_RATE_2M:  tdms_chan_ok = (chan <= CHAN_MAX_2M);
      TDMS_RATE_4M:  tdms_chan_ok = (chan <= CHAN_MAX_4M);
      TDMS_RATE_8M:  tdms_chan_ok = (chan <= CHAN_MAX_8M);
      TDMS_RATE_16M: tdms_chan_ok = (chan <= CHAN_MAX_16M);
    endcase
  endfunction : tdms_chan_ok

endpackage : tdms_pkg

// >>> rtl/tdms_ber_if.sv
`timescale 1ns/1ps
interface tdms_ber_if;
  import tdms_pkg::*;
  logic [NUM_STREAMS-1:0] err;
  logic [NUM_STREAMS-1:0] clr;
  logic [STREAM_W-1:0]    index;
  logic [DATA_W-1:0]      count;
  modport ctrl (output err, output clr, output index, input count);
  modport bank (input err, input clr, input index, output count);
endinterface : tdms_ber_if

// >>> rtl/tdms_ber_bank.sv
`timescale 1ns/1ps
module tdms_ber_bank #(
  parameter int STREAMS = 32
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  tdms_ber_if.bank   ber
);
  import tdms_pkg::*;

  // a bank of another size would not line up with the five index bits of the map
  if (STREAMS != NUM_STREAMS) begin : g_bad_streams
    $error("stream count must match the address map");
  end

  logic [DATA_W-1:0] cnt_q [STREAMS];

  // per-stream counters; a clear in the same cycle as an error leaves one count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < STREAMS; i++) cnt_q[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < STREAMS; i++) begin
        if (ber.clr[i]) begin
          cnt_q[i] <= ber.err[i] ? 16'h0001 : 16'h0000;
        end else if (ber.err[i] && cnt_q[i] != BER_COUNT_MAX) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001; // sticks at the top [RULE8]
        end
      end
    end
  end

  assign ber.count = cnt_q[ber.index];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // every lane is watched; one fixed lane would miss the streams that see errors
  for (genvar g = 0; g < STREAMS; g++) begin : g_watch
    property p_ber_saturate;
      (cnt_q[g] == BER_COUNT_MAX) && !ber.clr[g] |=> cnt_q[g] == BER_COUNT_MAX;
    endproperty
    a_ber_saturate: assert property (p_ber_saturate) else $error("ber count wrapped"); // [RULE8]

    property p_ber_step;
      !ber.clr[g] && ber.err[g] && (cnt_q[g] != BER_COUNT_MAX) |=>
        cnt_q[g] == $past(cnt_q[g]) + 16'h0001;
    endproperty
    a_ber_step: assert property (p_ber_step) else $error("ber count missed an error"); // [RULE7]
  end

endmodule : tdms_ber_bank

// >>> dv/tdms_mem_model.sv
`timescale 1ns/1ps
// memory partner: answers a read within the request cycle
module tdms_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_sel,
  input  wire logic [4:0]  mem_stream,
  input  wire logic [7:0]  mem_chan,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] store [4][32][256];
  logic [15:0] junk_q = 16'h1234;
  // writes land at the edge closing the request cycle
  always_ff @(posedge clk) begin
    if (mem_req && mem_we) store[mem_sel][mem_stream][mem_chan] <= mem_wdata;
  end
  // toggles each cycle so a mistimed sample cannot match
  always @(posedge clk) junk_q <= ~junk_q;
  assign mem_rdata = (mem_req && !mem_we) ? store[mem_sel][mem_stream][mem_chan] : junk_q;
endmodule : tdms_mem_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import tdms_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        host_wr;
  logic        host_rd;
  logic        host_rvalid;
  logic        mem_req;
  logic        mem_we;
  logic [13:0] host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [63:0] stream_rate;
  logic [31:0] ber_error;
  logic [31:0] ber_clear;
  logic [1:0]  mem_sel;
  logic [4:0]  mem_stream;
  logic [7:0]  mem_chan;
  logic [1:0]  sel;
  logic [7:0]  cmax;
  int          err_total;
  int          checks_done;

  tdms_addr_map dut (.clk(clk), .reset_n(reset_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .stream_rate(stream_rate),
    .ber_error(ber_error), .ber_clear(ber_clear), .mem_req(mem_req), .mem_we(mem_we),
    .mem_sel(mem_sel), .mem_stream(mem_stream), .mem_chan(mem_chan),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  tdms_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_sel(mem_sel),
    .mem_stream(mem_stream), .mem_chan(mem_chan), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  // one-cycle write strobe, memory side looked at in the following cycle
  task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic req);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    #1;
    `CHK(mem_req, req)
    if (req) `CHK({mem_we, mem_sel, mem_stream, mem_chan, mem_wdata}, {1'b1, sel, a[12:0], d})
  endtask : wr

  // answer is due exactly one cycle after the taking edge
  task automatic rd(input logic [13:0] a, input logic [15:0] e);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({host_rvalid, host_rdata}, {1'b1, e})
  endtask : rd

  task automatic setsel(input logic [1:0] s);
    sel = s;
    wr(14'h0000, {14'h0, s}, 1'b0);
    rd(14'h0000, {14'h0, s});
  endtask : setsel

  task summarize;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the long saturation run sets the span
  initial begin
    #3_500_000;
    err_total++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    host_addr = '0;
    host_wdata = '0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    stream_rate = '0;
    ber_error = '0;
    ber_clear = '0;
    sel = 2'h0;
    err_total = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(14'h0000, 16'h0000);
    rd(14'h037F, 16'h0000);
    // same location, three memories, then read back under each select
    for (int s = 0; s < 3; s++) begin
      setsel(s[1:0]);
      wr(14'h2507, 16'hC0D0 + 16'(s), 1'b1);
    end
    for (int s = 0; s < 3; s++) begin
      setsel(s[1:0]);
      rd(14'h2507, 16'hC0D0 + 16'(s));
    end
    wr(14'h1507, 16'h5555, 1'b0);
    rd(14'h1507, 16'h0000);
    // streams 0-7 lowest rate up to 24-31 highest rate
    @(posedge clk);
    stream_rate <= 64'hFFFF_AAAA_5555_0000;
    for (int r = 0; r < 4; r++) begin
      cmax = 8'((32 << r) - 1);
      wr({1'b1, 5'(r * 8 + 1), cmax}, 16'hBE00 + 16'(r), 1'b1);
      rd({1'b1, 5'(r * 8 + 1), cmax}, 16'hBE00 + 16'(r));
      if (r < 3) wr({1'b1, 5'(r * 8 + 1), cmax + 8'h01}, 16'h1111, 1'b0);
    end
    setsel(2'h3);
    wr(14'h2507, 16'h2222, 1'b0);
    rd(14'h2507, 16'h0000);
    setsel(2'h0);
    // five error events on stream 3, write attempt, then clear
    repeat (5) begin
      @(posedge clk);
      ber_error <= 32'h0000_0008;
      @(posedge clk);
      ber_error <= 32'h0;
    end
    rd(14'h0363, 16'h0005);
    wr(14'h0363, 16'h7777, 1'b0);
    rd(14'h0363, 16'h0005);
    @(posedge clk);
    ber_clear <= 32'h0000_0008;
    @(posedge clk);
    ber_clear <= 32'h0;
    rd(14'h0363, 16'h0000);
    // more events than the count can hold, last stream
    @(posedge clk);
    ber_error <= 32'h8000_0000;
    repeat (65540) @(posedge clk);
    ber_error <= 32'h0;
    rd(14'h037F, 16'hFFFF);
    rd(14'h037E, 16'h0000);
    summarize();
  end
endmodule : testbench
